// File: logic/rfc_crc16.sv
// byte-wide crc-16 engine, one byte per clock
// assumes the user pulses feed once per byte, with first on the frame's first byte
`timescale 1ns/100ps
module rfc_crc16
    import rfc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // byte feed
    rfc_crc_if.engine crc
);
    logic [15:0] crc_reg;
    logic [15:0] crc_next;
    logic [15:0] seed;

    assign seed = crc.first ? CRC_INIT : crc_reg; // R14
    assign crc_next = crc.feed ? crc_step(seed, crc.data) : crc_reg; // R13 R15 R19
    assign crc.value = crc_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= CRC_INIT;
        end else begin
            crc_reg <= crc_next;
        end
    end
endmodule // rfc_crc16

// File: logic/rfc_crc_if.sv
// carrier between the framer and its crc engines
// assumes engine and user share clk_sys
`timescale 1ns/100ps
interface rfc_crc_if;
    logic feed;
    logic first;
    logic [7:0] data;
    logic [15:0] value;
    modport engine (input feed, input first, input data, output value);
    modport user (output feed, output first, output data, input value);
endinterface

// File: logic/rfc_frame_checker.sv
// rtu framer: serial receive with gap framing and checks, transmit with crc append
// assumes rx_line synchronous to clk_sys and an external half-duplex transceiver
// What this block does
// R1: gap over 1.5 characters drops partial frame
// R2: keep 3.5 character idle between frames
// R3: order address, function, data, crc low, high
// R4: address 0 to 247, 0 is broadcast
// R5: function 03h reads, 06h writes
// R6: data field holds whole 16-bit words
// R7: 16-bit crc, low byte sent first
// R8: parity even, odd or none selectable
// R9: even parity bit set on odd ones
// R10: odd parity bit set on even ones
// R11: receiver flags parity mismatch per character
// R12: sender appends crc over whole frame
// R13: crc covers data bits only
// R14: crc starts at ffff each frame
// R15: xor byte, eight right shifts with poly
// R16: receiver compares crc, reports mismatch
// R17: start, 7/8 data lsb first, parity, stops
// R18: no reply to broadcast, only own address
// R19: shift polynomial is reflected a001
// R20: gap thresholds counted from baud setting
`timescale 1ns/100ps
module rfc_frame_checker
    import rfc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // configuration
    input wire logic [DIV_W-1:0] bit_div,
    input wire logic data_eight,
    input wire rfc_pkg::rfc_parity_e parity_mode,
    input wire logic [7:0] station_addr,
    // serial line
    input wire logic rx_line,
    output logic tx_line,
    output logic tx_oe_n,
    // received bytes
    output logic [7:0] rx_data,
    output logic rx_valid,
    output rfc_pkg::rfc_field_e rx_field,
    // received frame verdict
    output logic frame_ok,
    output logic frame_bcast,
    output logic frame_fn_known,
    output logic frame_drop,
    output logic parity_err,
    output logic crc_err,
    // transmit payload
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ack,
    output logic tx_busy
);
    import rfc_pkg::*;

    typedef enum logic [2:0] {SER_IDLE, SER_START, SER_BITS, SER_PAR, SER_STOP} rfc_ser_e;

    rfc_crc_if crc_rx ();
    rfc_crc_if crc_tx ();
    rfc_crc16 u_crc_rx (.clk_sys(clk_sys), .rst_n(rst_n), .crc(crc_rx));
    rfc_crc16 u_crc_tx (.clk_sys(clk_sys), .rst_n(rst_n), .crc(crc_tx));

    ////////////////////////////////////////////////////////////////////////////
    // shared decode
    logic par_on;
    logic [3:0] data_last;
    logic [DIV_W-1:0] div_m1;
    logic [CNT_W-1:0] gap_abort;
    logic [CNT_W-1:0] gap_frame;

    assign par_on = (parity_mode == PAR_EVEN) || (parity_mode == PAR_ODD); // R8
    assign data_last = (data_eight ? DATA_BITS_8 : DATA_BITS_7) - 4'h1; // R17
    assign div_m1 = bit_div - DIV_W'(1);
    assign gap_abort = gap_clocks(bit_div, data_eight, par_on, GAP_ABORT_HALVES); // R20
    assign gap_frame = gap_clocks(bit_div, data_eight, par_on, GAP_FRAME_HALVES); // R20

    ////////////////////////////////////////////////////////////////////////////
    // receive deserialiser
    rfc_ser_e rx_state_reg;
    logic [DIV_W-1:0] rx_baud_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_sr_reg;
    logic rx_par_reg;
    logic rx_tick;
    logic char_done;
    logic [7:0] rx_byte;
    logic char_par_bad;

    assign rx_tick = (rx_baud_reg == '0);
    assign char_done = (rx_state_reg == SER_STOP) && rx_tick;
    assign rx_byte = data_eight ? rx_sr_reg : {1'b0, rx_sr_reg[7:1]}; // R17
    // stop bit low counts as a character fault too
    assign char_par_bad = (par_on && (rx_par_reg != par_bit(rx_byte, data_eight, parity_mode)))
                        || !rx_line; // R9 R10 R11

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= SER_IDLE;
            rx_baud_reg <= '0;
            rx_bit_reg <= '0;
            rx_sr_reg <= '0;
            rx_par_reg <= 1'b0;
        end else begin
            rx_baud_reg <= rx_tick ? div_m1 : rx_baud_reg - DIV_W'(1);
            case (rx_state_reg)
                SER_IDLE: begin
                    // own echo ignored while we drive the pair
                    if (!rx_line && tx_oe_n) begin
                        rx_state_reg <= SER_START;
                        rx_baud_reg <= bit_div >> 1;
                    end
                end
                SER_START: if (rx_tick) begin
                    rx_state_reg <= rx_line ? SER_IDLE : SER_BITS;
                    rx_bit_reg <= '0;
                end
                SER_BITS: if (rx_tick) begin
                    rx_sr_reg <= {rx_line, rx_sr_reg[7:1]}; // R17
                    rx_bit_reg <= rx_bit_reg + 4'h1;
                    if (rx_bit_reg == data_last) begin
                        rx_state_reg <= par_on ? SER_PAR : SER_STOP;
                    end
                end
                SER_PAR: if (rx_tick) begin
                    rx_par_reg <= rx_line;
                    rx_state_reg <= SER_STOP;
                end
                SER_STOP: if (rx_tick) begin
                    rx_state_reg <= SER_IDLE;
                end
                default: rx_state_reg <= SER_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive framing
    logic frm_active_reg;
    logic [7:0] frm_len_reg;
    logic [7:0] frm_addr_reg;
    logic [7:0] frm_fn_reg;
    logic frm_bad_reg;
    logic [CNT_W-1:0] gap_reg;
    logic frm_close;
    logic frm_shape_ok;
    logic frm_crc_ok;
    logic frm_for_us;
    logic frm_good;
    logic reply_ok_reg;

    assign crc_rx.feed = char_done;
    assign crc_rx.first = !frm_active_reg; // R14
    assign crc_rx.data = rx_byte; // R13
    // silence past 1.5 characters ends whatever was collected
    assign frm_close = frm_active_reg && (gap_reg == gap_abort); // R1
    assign frm_shape_ok = (frm_len_reg >= MIN_FRAME_LEN) && !frm_len_reg[0]
                        && (frm_addr_reg <= ADDR_MAX); // R3 R4 R6
    assign frm_crc_ok = (crc_rx.value == CRC_RESIDUE); // R7 R16
    assign frm_for_us = (frm_addr_reg == station_addr) || (frm_addr_reg == ADDR_BCAST); // R4
    assign frm_good = frm_shape_ok && frm_crc_ok && !frm_bad_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= '0;
        end else if (rx_state_reg != SER_IDLE || char_done) begin
            gap_reg <= '0;
        end else if (gap_reg != '1) begin
            gap_reg <= gap_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frm_active_reg <= 1'b0;
            frm_len_reg <= '0;
            frm_addr_reg <= '0;
            frm_fn_reg <= '0;
            frm_bad_reg <= 1'b0;
        end else if (char_done) begin
            frm_active_reg <= 1'b1;
            frm_len_reg <= frm_active_reg ? frm_len_reg + 8'h01 : 8'h01;
            frm_bad_reg <= (frm_active_reg && frm_bad_reg) || char_par_bad; // R11
            if (!frm_active_reg) begin
                frm_addr_reg <= rx_byte; // R1 R3
            end
            if (frm_len_reg == 8'h01 && frm_active_reg) begin
                frm_fn_reg <= rx_byte; // R3
            end
        end else if (frm_close) begin
            frm_active_reg <= 1'b0; // R1
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= '0;
            rx_valid <= 1'b0;
            rx_field <= FLD_ADDR;
            frame_ok <= 1'b0;
            frame_bcast <= 1'b0;
            frame_fn_known <= 1'b0;
            frame_drop <= 1'b0;
            parity_err <= 1'b0;
            crc_err <= 1'b0;
        end else begin
            rx_valid <= char_done;
            parity_err <= char_done && char_par_bad; // R11
            frame_ok <= frm_close && frm_good && frm_for_us;
            frame_drop <= frm_close && !frm_good; // R1
            crc_err <= frm_close && frm_shape_ok && !frm_crc_ok; // R16
            if (char_done) begin
                rx_data <= rx_byte;
                rx_field <= !frm_active_reg ? FLD_ADDR
                          : (frm_len_reg == 8'h01) ? FLD_FUNC : FLD_BODY; // R3
            end
            if (frm_close) begin
                frame_bcast <= (frm_addr_reg == ADDR_BCAST); // R4
                frame_fn_known <= (frm_fn_reg == FN_READ) || (frm_fn_reg == FN_WRITE); // R5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit serialiser
    rfc_ser_e tx_state_reg;
    rfc_txsel_e tx_sel_reg;
    logic [DIV_W-1:0] tx_baud_reg;
    logic [3:0] tx_bit_reg;
    logic [7:0] tx_sr_reg;
    logic tx_par_reg;
    logic tx_in_frame_reg;
    logic [CNT_W-1:0] quiet_reg;
    logic tx_tick;
    logic quiet_ok;
    logic take_body;
    logic take_crc;
    logic [7:0] load_byte;
    logic stop_done;

    assign tx_tick = (tx_baud_reg == '0);
    assign quiet_ok = (quiet_reg >= gap_frame); // R2
    assign take_body = (tx_state_reg == SER_IDLE) && (tx_sel_reg == SEL_BODY) && tx_valid
                     && !tx_ack && (tx_in_frame_reg || (quiet_ok && reply_ok_reg)); // R2 R18
    assign take_crc = (tx_state_reg == SER_IDLE)
                    && (tx_sel_reg == SEL_CRC_LO || tx_sel_reg == SEL_CRC_HI); // R12
    assign load_byte = (tx_sel_reg == SEL_CRC_LO) ? crc_tx.value[7:0]
                     : (tx_sel_reg == SEL_CRC_HI) ? crc_tx.value[15:8] : tx_data; // R7
    assign stop_done = (tx_state_reg == SER_STOP) && tx_tick
                     && (tx_bit_reg == (par_on ? STOP_BITS_PAR : STOP_BITS_NOPAR) - 4'h1); // R17
    assign crc_tx.feed = take_body;
    assign crc_tx.first = !tx_in_frame_reg; // R14
    assign crc_tx.data = tx_data; // R12 R13

    // line quiet time, reset by traffic in either direction
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            quiet_reg <= '0;
        end else if (rx_state_reg != SER_IDLE || tx_state_reg != SER_IDLE) begin
            quiet_reg <= '0;
        end else if (quiet_reg != '1) begin
            quiet_reg <= quiet_reg + CNT_W'(1);
        end
    end

    // reply permission: own good frame sets it, starting the reply or any other frame close withdraws it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reply_ok_reg <= 1'b0;
        end else if (frm_close && frm_good && frm_addr_reg == station_addr
                     && frm_addr_reg != ADDR_BCAST) begin
            reply_ok_reg <= 1'b1; // R18
        end else if (frm_close || (take_body && !tx_in_frame_reg)) begin
            reply_ok_reg <= 1'b0; // R18
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= SER_IDLE;
            tx_sel_reg <= SEL_BODY;
            tx_baud_reg <= '0;
            tx_bit_reg <= '0;
            tx_sr_reg <= '0;
            tx_par_reg <= 1'b0;
            tx_in_frame_reg <= 1'b0;
            tx_line <= 1'b1;
            tx_oe_n <= 1'b1;
            tx_ack <= 1'b0;
            tx_busy <= 1'b0;
        end else begin
            tx_ack <= take_body;
            tx_busy <= tx_in_frame_reg || take_body;
            tx_baud_reg <= tx_tick ? div_m1 : tx_baud_reg - DIV_W'(1);
            case (tx_state_reg)
                SER_IDLE: if (take_body || take_crc) begin
                    tx_state_reg <= SER_START;
                    tx_sr_reg <= load_byte;
                    tx_par_reg <= par_bit(load_byte, data_eight, parity_mode); // R9 R10
                    tx_baud_reg <= div_m1;
                    tx_line <= 1'b0;
                    tx_oe_n <= 1'b0;
                    tx_in_frame_reg <= 1'b1;
                    tx_sel_reg <= (tx_sel_reg == SEL_BODY) ? (tx_last ? SEL_CRC_LO : SEL_BODY)
                                : (tx_sel_reg == SEL_CRC_LO) ? SEL_CRC_HI : SEL_DONE; // R3 R7
                end
                SER_START: if (tx_tick) begin
                    tx_state_reg <= SER_BITS;
                    tx_bit_reg <= '0;
                    tx_line <= tx_sr_reg[0]; // R17
                end
                SER_BITS: if (tx_tick) begin
                    tx_bit_reg <= tx_bit_reg + 4'h1;
                    tx_sr_reg <= tx_sr_reg >> 1;
                    if (tx_bit_reg == data_last) begin
                        tx_state_reg <= par_on ? SER_PAR : SER_STOP; // R8
                        tx_line <= par_on ? tx_par_reg : 1'b1;
                        tx_bit_reg <= '0;
                    end else begin
                        tx_line <= tx_sr_reg[1];
                    end
                end
                SER_PAR: if (tx_tick) begin
                    tx_state_reg <= SER_STOP;
                    tx_line <= 1'b1;
                    tx_bit_reg <= '0;
                end
                SER_STOP: if (tx_tick) begin
                    tx_bit_reg <= tx_bit_reg + 4'h1;
                    if (stop_done) begin
                        tx_state_reg <= SER_IDLE;
                        if (tx_sel_reg == SEL_DONE) begin
                            tx_sel_reg <= SEL_BODY;
                            tx_in_frame_reg <= 1'b0;
                            tx_oe_n <= 1'b1;
                        end
                    end
                end
                default: tx_state_reg <= SER_IDLE;
            endcase
        end
    end
endmodule // rfc_frame_checker

// File: logic/rfc_pkg.sv
// constants and types for the rtu serial frame checker
// assumes a single 50 MHz system clock and byte-wide user streams
package rfc_pkg;

    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_RSVD} rfc_parity_e;
    typedef enum logic [1:0] {FLD_ADDR, FLD_FUNC, FLD_BODY, FLD_RSVD} rfc_field_e;
    typedef enum logic [1:0] {SEL_BODY, SEL_CRC_LO, SEL_CRC_HI, SEL_DONE} rfc_txsel_e;

    localparam int CLK_HZ = 50_000_000;
    localparam int CNT_W = 24;
    localparam int DIV_W = 16;

    // character shape
    localparam logic [3:0] START_BITS = 4'h1;
    localparam logic [3:0] DATA_BITS_7 = 4'h7;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] STOP_BITS_PAR = 4'h1;
    localparam logic [3:0] STOP_BITS_NOPAR = 4'h2;

    // gaps in half character times: 1.5 and 3.5 characters
    localparam logic [3:0] GAP_ABORT_HALVES = 4'h3;
    localparam logic [3:0] GAP_FRAME_HALVES = 4'h7;

    // frame check
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    // frame content
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] ADDR_MAX = 8'hf7;
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE = 8'h06;
    localparam logic [7:0] MIN_FRAME_LEN = 8'h04;

    // one byte through the reflected crc shift register
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        c = crc ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // parity bit that goes with a character; 7-bit mode ignores bit 7
    function automatic logic par_bit(input logic [7:0] d, input logic eight,
                                     input rfc_parity_e mode);
        logic ones;
        ones = ^(eight ? d : {1'b0, d[6:0]});
        return (mode == PAR_ODD) ? ~ones : ones;
    endfunction

    // gap length in clocks from bit period, character shape and halves
    function automatic logic [CNT_W-1:0] gap_clocks(input logic [DIV_W-1:0] div,
                                                    input logic eight,
                                                    input logic par_on,
                                                    input logic [3:0] halves);
        logic [3:0] bits;
        logic [CNT_W+3:0] p;
        bits = START_BITS + (eight ? DATA_BITS_8 : DATA_BITS_7)
             + (par_on ? (4'h1 + STOP_BITS_PAR) : STOP_BITS_NOPAR);
        p = CNT_W'(div) * CNT_W'(bits) * CNT_W'(halves);
        return p[CNT_W:1];
    endfunction

endpackage

// File: tb/rfc_frame_checker_props.sv
// pin-level assertions for the rtu framer
// assumes bit_div of at least 2, so one character spans 20 clocks or more
`timescale 1ns/100ps
module rfc_frame_checker_props
    import rfc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // receive side
    input wire logic rx_valid,
    input wire logic parity_err,
    input wire logic frame_ok,
    input wire logic frame_drop,
    input wire logic crc_err,
    // transmit side
    input wire logic tx_line,
    input wire logic tx_oe_n,
    input wire logic tx_ack,
    input wire logic tx_busy
);
    import rfc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    chk_ack_pulse: assert property (tx_ack |=> !tx_ack)
        else $error("tx_ack held past one cycle");
    chk_ack_start: assert property (tx_ack |-> !tx_line && !tx_oe_n && tx_busy)
        else $error("start bit not driven with tx_ack");
    chk_char_hold: assert property (tx_ack |-> ##1 (!tx_oe_n)[*8])
        else $error("driver released inside a character");
    chk_idle_mark: assert property (tx_oe_n |-> tx_line)
        else $error("tx_line low while not driving");
    chk_busy_end: assert property ($fell(tx_busy) |-> $past(tx_oe_n))
        else $error("tx_busy fell before driver release");
    chk_rx_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("rx_valid longer than one cycle");
    chk_parity_char: assert property (parity_err |-> rx_valid)
        else $error("parity_err without a character");
    chk_gap_wait: assert property (rx_valid |=> (!(frame_ok || frame_drop))[*8])
        else $error("frame closed without an idle gap");
    chk_close_excl: assert property (!(frame_ok && frame_drop))
        else $error("frame both accepted and dropped");
    chk_crc_drop: assert property (crc_err |-> frame_drop && !frame_ok)
        else $error("crc error without a drop");
    ////////////////////////////////////////
    cover property (frame_ok);
    cover property (crc_err);
    cover property (parity_err);
    cover property (tx_ack);
endmodule // rfc_frame_checker_props

bind rfc_frame_checker rfc_frame_checker_props rfc_frame_checker_props_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .parity_err(parity_err),
    .frame_ok(frame_ok), .frame_drop(frame_drop), .crc_err(crc_err), .tx_line(tx_line),
    .tx_oe_n(tx_oe_n), .tx_ack(tx_ack), .tx_busy(tx_busy)
);

// File: tb/rfc_frame_checker_tb.sv
// self-checking bench for the rtu framer
// assumes a master model on the line and short bit times (bit_div 8)
`timescale 1ns/100ps
module rfc_frame_checker_tb;
    import rfc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [DIV_W-1:0] bit_div = 16'h0008;
    logic data_eight = 1'b1;
    rfc_parity_e parity_mode = PAR_NONE;
    logic [7:0] station_addr = 8'h11;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic tx_last = 1'b0;
    logic rx_line, tx_line, tx_oe_n, rx_valid, frame_ok, frame_bcast, frame_fn_known;
    logic frame_drop, parity_err, crc_err, tx_ack, tx_busy, seen;
    logic [7:0] rx_data;
    rfc_field_e rx_field;
    logic [10:0] rxq[$];
    logic [2:0] evq[$];
    logic [7:0] txq[$];
    logic [7:0] fr[$];
    logic [10:0] note;
    logic [2:0] evn;
    logic [16:0] lf = 17'h10a6a;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;
    rfc_parity_e modes[3] = '{PAR_NONE, PAR_EVEN, PAR_ODD};

    always #10 clk_sys = ~clk_sys;

    rfc_frame_checker rfc_frame_checker_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .bit_div(bit_div), .data_eight(data_eight),
        .parity_mode(parity_mode), .station_addr(station_addr), .rx_line(rx_line),
        .tx_line(tx_line), .tx_oe_n(tx_oe_n), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_field(rx_field), .frame_ok(frame_ok), .frame_bcast(frame_bcast),
        .frame_fn_known(frame_fn_known), .frame_drop(frame_drop), .parity_err(parity_err),
        .crc_err(crc_err), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ack(tx_ack), .tx_busy(tx_busy)
    );
    rfc_master_model rfc_master_model_i (
        .clk_sys(clk_sys), .bit_div(bit_div), .parity_mode(parity_mode),
        .tx_line(tx_line), .tx_oe_n(tx_oe_n), .rx_line(rx_line)
    );
    ////////////////////////////////////////
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // random body of whole words, crc appended low byte first
    task automatic mk(input logic [7:0] a, input logic [7:0] fn, input int w,
                      input logic [15:0] bad);
        logic [15:0] c;
        fr = {a, fn};
        repeat (2 * w) begin
            lf = lfsr_next(lf);
            fr.push_back(lf[7:0]);
        end
        c = crc_of(fr) ^ bad;
        fr.push_back(c[7:0]);
        fr.push_back(c[15:8]);
    endtask
    task automatic send(input int bp, input logic [2:0] ev, input int gap);
        foreach (fr[i]) begin
            rxq.push_back({i == bp, i == 0 ? FLD_ADDR : i == 1 ? FLD_FUNC : FLD_BODY, fr[i]});
            rfc_master_model_i.send_char(fr[i], i == bp);
        end
        if (ev !== 3'b000) evq.push_back(ev);
        repeat (gap * 11 * bit_div) @(negedge clk_sys);
    endtask
    task automatic reply(input int n);
        int w;
        mk(station_addr, FN_READ, (n - 2) / 2, 16'h0000);
        txq = fr;
        for (int i = 0; i < n; i++) begin
            tx_data = fr[i];
            tx_valid = 1'b1;
            tx_last = (i == n - 1);
            w = 0;
            do begin @(negedge clk_sys); w++; end while (tx_ack !== 1'b1 && w < 2000);
            chk("tx_ack", tx_ack, 1'b1);
        end
        tx_valid = 1'b0;
        tx_last = 1'b0;
        w = 0;
        while (tx_busy !== 1'b0 && w < 4000) begin @(negedge clk_sys); w++; end
        chk("tx_busy", tx_busy, 1'b0);
        repeat (4 * 11 * bit_div) @(negedge clk_sys);
    endtask
    ////////////////////////////////////////
    always @(negedge clk_sys) begin
        if (rx_valid === 1'b1) begin
            note = rxq.size() > 0 ? rxq.pop_front() : 11'h7ff;
            chk("rx char", {5'h00, parity_err, rx_field, rx_data}, {5'h00, note});
        end
        if ((frame_ok | frame_drop | crc_err) === 1'b1) begin
            evn = evq.size() > 0 ? evq.pop_front() : 3'b111;
            chk("frame close", {13'h0, frame_ok, frame_drop, crc_err}, {13'h0, evn});
        end
    end
    always @(rfc_master_model_i.got_ev) begin
        chk("tx char", {7'h0, rfc_master_model_i.got_perr, rfc_master_model_i.got_data},
            {8'h0, txq.size() > 0 ? txq.pop_front() : 8'hxx});
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (50) @(negedge clk_sys);
        foreach (modes[m]) begin
            parity_mode = modes[m];
            mk(8'h11, FN_READ, 2, 16'h0000);
            send(-1, 3'b100, 4);
            chk("fn_known", frame_fn_known, 1'b1);
            chk("bcast", frame_bcast, 1'b0);
            reply(4);
            $display("test mode %0d done", m);
        end
        mk(8'h11, FN_WRITE, 2, 16'h0000);
        send(2, 3'b010, 4);
        mk(8'h11, FN_READ, 1, 16'h0100);
        send(-1, 3'b011, 4);
        $display("test bad checks done");
        mk(8'h11, FN_READ, 0, 16'h0000);
        void'(fr.pop_back());
        send(-1, 3'b010, 2);
        mk(8'h11, FN_READ, 1, 16'h0000);
        send(-1, 3'b100, 4);
        $display("test gap done");
        mk(8'hf7, FN_READ, 1, 16'h0000);
        send(-1, 3'b000, 4);
        mk(8'hf8, FN_READ, 1, 16'h0000);
        send(-1, 3'b010, 4);
        mk(8'h00, FN_WRITE, 1, 16'h0000);
        send(-1, 3'b100, 4);
        chk("bcast", frame_bcast, 1'b1);
        tx_data = 8'h11;
        tx_valid = 1'b1;
        seen = 1'b0;
        repeat (300) begin @(negedge clk_sys); seen = seen | tx_ack; end
        chk("bcast reply", seen, 1'b0);
        tx_valid = 1'b0;
        mk(8'h11, 8'h10, 1, 16'h0000);
        send(-1, 3'b100, 4);
        chk("fn_known", frame_fn_known, 1'b0);
        $display("test address done");
        report_and_stop();
    end
endmodule // rfc_frame_checker_tb

// File: tb/rfc_master_model.sv
// bus master model: drives the receive line, decodes the slave reply
// assumes 8 data bits and that send_char is entered at a falling edge
`timescale 1ns/100ps
module rfc_master_model
    import rfc_pkg::*;
(
    // clock and config
    input wire logic clk_sys,
    input wire logic [DIV_W-1:0] bit_div,
    input wire rfc_pkg::rfc_parity_e parity_mode,
    // serial line
    input wire logic tx_line,
    input wire logic tx_oe_n,
    output logic rx_line
);
    import rfc_pkg::*;
    logic [7:0] got_data;
    logic got_perr;
    logic par_on;
    event got_ev;
    assign par_on = (parity_mode == PAR_EVEN) || (parity_mode == PAR_ODD);
    // biased pair idles at mark
    initial rx_line = 1'b1;
    ////////////////////////////////////////
    task automatic put_bit(input logic b);
        rx_line = b;
        repeat (bit_div) @(negedge clk_sys);
    endtask
    // bad flips the parity bit on purpose
    task automatic send_char(input logic [7:0] d, input logic bad);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) put_bit(d[i]);
        if (par_on) put_bit(^d ^ (parity_mode == PAR_ODD) ^ bad);
        put_bit(1'b1);
        if (!par_on) put_bit(1'b1);
    endtask
    ////////////////////////////////////////
    // mid-bit sampling of the reply
    always begin
        @(negedge clk_sys);
        if (!tx_oe_n && !tx_line) begin
            repeat (bit_div / 2) @(negedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_div) @(negedge clk_sys);
                got_data[i] = tx_line;
            end
            got_perr = 1'b0;
            if (par_on) begin
                repeat (bit_div) @(negedge clk_sys);
                got_perr = tx_line !== (^got_data ^ (parity_mode == PAR_ODD));
            end
            repeat (bit_div) @(negedge clk_sys);
            got_perr = got_perr | (tx_line !== 1'b1);
            -> got_ev;
        end
    end
endmodule // rfc_master_model
